/* rtl/frame_header_rewrite_control.sv */
// frame header rewriter with input fifo
`timescale 1ns/1ps
`include "frame_hdr_regs.svh"

module frame_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg, rd_reg;
	logic [AW:0] count_reg, count_next;
	logic push, pop, ready_reg;
	assign push = i_valid && ready_reg;
	assign pop = i_ready && (count_reg != '0);
	assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign o_ready = ready_reg;
	assign o_valid = count_reg != '0;
	assign o_data = mem[rd_reg];
	always_ff @(posedge i_clock) begin
		if (push)
			mem[wr_reg] <= i_data;
	end
	// ready is a flop of its own, so the upstream sees no gate after it
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			count_reg <= '0;
			ready_reg <= 1'b1;
		end else begin
			wr_reg <= push ? AW'(wr_reg + 1'b1) : wr_reg;
			rd_reg <= pop ? AW'(rd_reg + 1'b1) : rd_reg;
			count_reg <= count_next;
			ready_reg <= count_next != (AW+1)'(DEPTH);
		end
	end
endmodule // frame_fifo

// Summary of operation
// [RQ1] action field bits 25:23: none, inject, masquerade, extract, loopbacks
// [RQ2] point field bits 22:18: zero none, 1-16 analyzer, 17-25 rewriter
// [RQ3] mask bits 17:10 picks the cpu extraction queues
// [RQ4] rewriter drops as many vlan tags as count bits 9:8 say
// [RQ5] with encap strip and ethernet after it, tags pop from inner layer
// [RQ6] keep bit 7 stops diffserv remapping on front ports
// [RQ7] update bit 6 writes diffserv bits 5:0 into front port frames; code writes ipv4 only, type right after popped tags
// [RQ8] header only steers rewriting or cpu delivery, never transmitted
// [RQ9] cpu side treats extraction header as reference only
// [RQ10] optional stacking header inserted toward node processor or stack
// [RQ11] stacking header is 2-byte ethertype plus 10-byte payload, 12 bytes
// [RQ12] encap count strips that many 2-byte units from frame start
// [RQ13] kind zero means plain ethernet starting at destination mac
// [RQ14] reserved action or unlisted point behave as no action
module frame_header_rewrite_control
	import frame_hdr_pkg::*;
#(
	// arbitrary neutral value
	parameter logic [15:0] STACK_ETHERTYPE = 16'h1234
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire in_word_type i_in,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [`STACK_PAYLOAD_BITS-1:0] i_stack_payload,
	output out_word_type o_out,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic o_to_cpu,
	output logic [7:0] o_cpu_queue_mask,
	output logic [2:0] o_frame_path_action,
	output logic [4:0] o_frame_path_point,
	output logic o_runt_frame
);
	in_word_type f_word, hdr_reg, hdr_cur;
	logic f_valid, f_ready;
	frame_fifo #(.WIDTH($bits(in_word_type)), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_valid(i_in_valid),
		.o_ready(o_in_ready),
		.i_data(i_in),
		.o_valid(f_valid),
		.i_ready(f_ready),
		.o_data(f_word)
	);

	function automatic logic [7:0] stack_byte(input logic [3:0] idx,
		input logic [15:0] etype, input logic [79:0] pay);
		logic [95:0] all;
		all = {etype, pay};
		stack_byte = all[8'(95 - 8 * idx) -: 8];
	endfunction

	out_word_type out_reg, out_next;
	logic out_valid_reg, cpu_reg, runt_reg, type_hi_reg, ipv4_reg;
	logic [7:0] mask_reg, pos_reg;
	logic [2:0] act_reg;
	logic [4:0] point_reg;
	logic [3:0] ins_reg;
	logic adv, action_ok, to_cpu, rewrite, eth_known, pop_apply;
	logic in_strip, in_pop, drop, insert_now, tos_hit, load, consume;
	logic [7:0] strip_bytes, eth_pos, pop_bytes, type_pos;

	assign hdr_cur = f_word.sof ? f_word : hdr_reg;
	// [RQ14] bad codes fall back
	assign action_ok = hdr_cur.internal_frame_header.frame_path_action != `ACT_RESERVED
		&& hdr_cur.internal_frame_header.frame_path_point <= `POINT_LAST;
	// [RQ1] extraction codes
	assign to_cpu = action_ok
		&& (hdr_cur.internal_frame_header.frame_path_action == `ACT_EXTRACT
		|| hdr_cur.internal_frame_header.frame_path_action == `ACT_EXTRACT_UP_MEP);
	// [RQ8] header steers rewriting or cpu delivery
	assign rewrite = !to_cpu;
	// [RQ13] kind zero is ethernet
	assign eth_known = hdr_cur.encap_halfword_strip_count == 5'h0
		|| hdr_cur.header_kind_after_strip == `KIND_ETHERNET;
	// [RQ5] pop on inner layer only
	assign pop_apply = rewrite && eth_known;
	// [RQ12] halfword strip
	assign strip_bytes = {2'h0, hdr_cur.encap_halfword_strip_count, 1'b0};
	assign in_strip = rewrite && pos_reg < strip_bytes;
	assign eth_pos = pos_reg - strip_bytes;
	// [RQ4] tag bytes after macs; tags are assumed present
	assign pop_bytes = pop_apply
		? 8'({hdr_cur.internal_frame_header.vlan_tag_strip_count, 2'b00}) : 8'h0;
	assign in_pop = !in_strip && eth_pos >= `MAC_BYTES
		&& eth_pos < `MAC_BYTES + pop_bytes;
	assign type_pos = `MAC_BYTES + pop_bytes;
	assign drop = in_strip || in_pop;
	// [RQ10] insertion point right after macs
	assign insert_now = f_valid && pop_apply && hdr_cur.stack_insert_enable
		&& !in_strip && eth_pos == `MAC_BYTES && ins_reg < `STACK_BYTES;
	// only untagged-after-pop ipv4 tos is reachable here
	assign tos_hit = pop_apply && !in_strip && ipv4_reg
		&& eth_pos == type_pos + `TOS_AFTER_TYPE;
	assign adv = !out_valid_reg || i_out_ready;
	assign f_ready = adv && !insert_now;
	assign consume = f_valid && f_ready;
	assign load = adv && (insert_now || (consume && !drop));

	always_comb begin
		out_next = '{data: f_word.data, sof: f_word.sof, eof: f_word.eof};
		if (insert_now) begin
			// [RQ11] twelve inserted bytes
			out_next.data = stack_byte(ins_reg, STACK_ETHERTYPE,
				i_stack_payload);
			out_next.sof = 1'b0;
			out_next.eof = 1'b0;
		// [RQ6] keep wins over update
		end else if (tos_hit && !hdr_cur.internal_frame_header.keep_diffserv_code
			&& hdr_cur.internal_frame_header.rewrite_diffserv_enable) begin
			// [RQ7] diffserv replaced, ecn kept
			out_next.data = {hdr_cur.internal_frame_header.diffserv_code, f_word.data[1:0]};
		end
		// first surviving byte opens the frame
		if (!insert_now && consume && pos_reg != 8'h0 && drop == 1'b0
			&& pos_reg == (rewrite ? strip_bytes : 8'h0)
			&& pos_reg != 8'h0)
			out_next.sof = 1'b1;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			out_reg <= '0;
			out_valid_reg <= 1'b0;
		end else if (adv) begin
			out_reg <= out_next;
			out_valid_reg <= load;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			hdr_reg <= '0;
			pos_reg <= 8'h0;
			ins_reg <= 4'h0;
			type_hi_reg <= 1'b0;
			ipv4_reg <= 1'b0;
		end else begin
			if (insert_now && adv)
				ins_reg <= ins_reg + 4'h1;
			if (consume) begin
				if (f_word.sof)
					hdr_reg <= f_word;
				pos_reg <= (pos_reg == 8'hff) ? pos_reg : pos_reg + 8'h1;
				type_hi_reg <= eth_pos == type_pos && !in_strip
					&& f_word.data == `IPV4_TYPE_HI;
				if (eth_pos == type_pos + 8'h1 && !in_strip)
					ipv4_reg <= type_hi_reg
						&& f_word.data == `IPV4_TYPE_LO;
				if (f_word.eof) begin
					pos_reg <= 8'h0;
					ins_reg <= 4'h0;
					ipv4_reg <= 1'b0;
				end
			end
		end
	end

	// per-frame steering for the cpu side
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			cpu_reg <= 1'b0;
			mask_reg <= 8'h0;
			act_reg <= `ACT_NONE;
			point_reg <= 5'h0;
			runt_reg <= 1'b0;
		end else begin
			runt_reg <= consume && f_word.eof && drop;
			if (consume && f_word.sof) begin
				cpu_reg <= to_cpu;
				// [RQ3] mask delivered with extracted frames
				mask_reg <= to_cpu ? f_word.internal_frame_header.cpu_queue_mask : 8'h0;
				// [RQ2] point kept only when listed
				act_reg <= action_ok ? f_word.internal_frame_header.frame_path_action
					: `ACT_NONE;
				point_reg <= action_ok ? f_word.internal_frame_header.frame_path_point : 5'h0;
			end
		end
	end

	assign o_out = out_reg;
	assign o_out_valid = out_valid_reg;
	assign o_to_cpu = cpu_reg;
	assign o_cpu_queue_mask = mask_reg;
	assign o_frame_path_action = act_reg;
	assign o_frame_path_point = point_reg;
	assign o_runt_frame = runt_reg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	a_action_no_reserved: assert property ( // [RQ1]
		o_frame_path_action != `ACT_RESERVED)
		else $error("reserved action reported");
	a_point_in_range: assert property ( // [RQ2]
		o_frame_path_point <= `POINT_LAST)
		else $error("unlisted point reported");
	a_mask_only_cpu: assert property ( // [RQ3]
		consume && f_word.sof |=> o_cpu_queue_mask ==
		(($past(f_word.internal_frame_header.frame_path_action) inside
		{`ACT_EXTRACT, `ACT_EXTRACT_UP_MEP})
		&& $past(f_word.internal_frame_header.frame_path_point) <= `POINT_LAST
		? $past(f_word.internal_frame_header.cpu_queue_mask) : 8'h0))
		else $error("cpu mask wrong");
	a_tag_bytes_dropped: assert property ( // [RQ4]
		consume && in_pop |-> !load)
		else $error("tag byte passed");
	a_inner_layer_pop: assert property ( // [RQ5]
		pop_bytes != 8'h0 |-> eth_known && rewrite)
		else $error("pop on unknown layer");
	a_keep_diffserv: assert property ( // [RQ6]
		load && tos_hit && hdr_cur.internal_frame_header.keep_diffserv_code
		|=> o_out.data == $past(f_word.data))
		else $error("kept diffserv changed");
	a_update_diffserv: assert property ( // [RQ7]
		load && tos_hit && !hdr_cur.internal_frame_header.keep_diffserv_code
		&& hdr_cur.internal_frame_header.rewrite_diffserv_enable
		|=> o_out.data[7:2] == $past(hdr_cur.internal_frame_header.diffserv_code))
		else $error("diffserv not written");
	a_cpu_frame_intact: assert property ( // [RQ8]
		consume && !rewrite |-> load ##1 o_out.data == $past(f_word.data))
		else $error("cpu frame modified");
	a_strip_dropped: assert property ( // [RQ12]
		consume && in_strip |-> !load)
		else $error("encap byte passed");
	a_stack_length: assert property ( // [RQ11]
		ins_reg <= `STACK_BYTES)
		else $error("stacking header overran");
endmodule // frame_header_rewrite_control

/* rtl/frame_hdr_regs.svh */
// constants for the frame header rewrite block
`ifndef FRAME_HDR_REGS_SVH
`define FRAME_HDR_REGS_SVH
`define ACT_NONE 3'h0
`define ACT_RESERVED 3'h3
`define ACT_EXTRACT 3'h4
`define ACT_EXTRACT_UP_MEP 3'h5
`define POINT_LAST 5'h19
`define KIND_ETHERNET 2'h0
`define MAC_BYTES 8'h0c
`define TAG_BYTES 8'h04
`define STACK_BYTES 4'hc
`define STACK_PAYLOAD_BITS 80
`define IPV4_TYPE_HI 8'h08
`define IPV4_TYPE_LO 8'h00
`define TOS_AFTER_TYPE 8'h03
`define FIFO_DEPTH 16
`endif

/* rtl/frame_hdr_pkg.sv */
// types for the frame header rewrite block
package frame_hdr_pkg;
	// low 26 bits of the internal frame header, msb first
	typedef struct packed {
		logic [2:0] frame_path_action;
		logic [4:0] frame_path_point;
		logic [7:0] cpu_queue_mask;
		logic [1:0] vlan_tag_strip_count;
		logic keep_diffserv_code;
		logic rewrite_diffserv_enable;
		logic [5:0] diffserv_code;
	} ifh_low_type;
	typedef struct packed {
		logic [7:0] data;
		logic sof;
		logic eof;
		logic [4:0] encap_halfword_strip_count;
		logic [1:0] header_kind_after_strip;
		logic stack_insert_enable;
		ifh_low_type internal_frame_header;
	} in_word_type;
	typedef struct packed {
		logic [7:0] data;
		logic sof;
		logic eof;
	} out_word_type;
endpackage

/* verification/frame_sink.sv */
// downstream sink model with stall control
`timescale 1ns/1ps
module frame_sink (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_slow,
	input wire logic i_hold,
	output logic o_ready
);
	logic phase_reg;
	always_ff @(posedge i_clock) begin
		phase_reg <= i_rst_n ? !phase_reg : 1'b0;
	end
	// steering outputs are reference only and never read here
	assign o_ready = !i_hold && (!i_slow || phase_reg);
endmodule // frame_sink

/* verification/test_frame_header_rewrite_control.sv */
// self-checking bench for the frame header rewriter
`timescale 1ns/1ps
module test_frame_header_rewrite_control
	import frame_hdr_pkg::*;
;
	localparam logic [15:0] ETY = 16'h5a5a;
	logic i_clock = 0, i_rst_n = 0, i_in_valid = 0, slow = 0, hold = 0;
	in_word_type i_in = '0;
	logic [79:0] pay = 80'h0102030405060708090a;
	out_word_type o_out;
	logic o_in_ready, o_out_valid, ready, o_to_cpu, o_runt_frame;
	logic [7:0] o_cpu_queue_mask, f[64], exp[$];
	logic [2:0] o_frame_path_action;
	logic [4:0] o_frame_path_point;
	out_word_type got[$];
	int n_mismatch = 0, n_compared = 0, n, n_runt = 0;
	always #20 i_clock = !i_clock;
	frame_header_rewrite_control #(.STACK_ETHERTYPE(ETY)) u_dut (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_in(i_in),
		.i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
		.i_stack_payload(pay), .o_out(o_out), .o_out_valid(o_out_valid),
		.i_out_ready(ready), .o_to_cpu(o_to_cpu),
		.o_cpu_queue_mask(o_cpu_queue_mask),
		.o_frame_path_action(o_frame_path_action),
		.o_frame_path_point(o_frame_path_point),
		.o_runt_frame(o_runt_frame));
	frame_sink u_sink (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_slow(slow), .i_hold(hold), .o_ready(ready));
	always @(posedge i_clock) begin
		if (o_out_valid === 1'b1 && ready === 1'b1)
			got.push_back(o_out);
		// one-cycle pulse, counted where it stands
		if (o_runt_frame === 1'b1)
			n_runt++;
	end
	task check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %0h want %0h", $time, seen, want);
		end
	endtask
	task put(input logic [7:0] b, input logic s, input logic e);
		i_in.data = b;
		i_in.sof = s;
		i_in.eof = e;
		i_in_valid = 1;
		while (o_in_ready !== 1'b1) @(negedge i_clock);
		@(negedge i_clock);
	endtask
	task send(input int len, input bit ip);
		int k, t, d, r0;
		bit cpu, bad, eth, tail;
		logic [2:0] act;
		logic [4:0] pt;
		logic [7:0] m;
		act = i_in.internal_frame_header.frame_path_action;
		pt = i_in.internal_frame_header.frame_path_point;
		bad = act == 3'h3 || pt > 5'h19;
		cpu = !bad && act inside {3'h4, 3'h5};
		k = cpu ? 0 : 2 * i_in.encap_halfword_strip_count;
		// pop, insertion and diffserv need ethernet after the strip
		eth = !cpu && (k == 0 || i_in.header_kind_after_strip == 2'h0);
		t = k + 12;
		if (eth)
			t = t + 4 * i_in.internal_frame_header.vlan_tag_strip_count;
		m = cpu ? i_in.internal_frame_header.cpu_queue_mask : 8'h0;
		for (int i = 0; i < len; i++) f[i] = 8'h20 + i;
		if (ip) begin
			f[t] = 8'h08;
			f[t + 1] = 8'h00;
		end
		exp = {};
		got = {};
		for (int i = 0; i < len; i++) begin
			if (cpu || (i >= k && i < k + 12) || i >= t) exp.push_back(f[i]);
			if (eth && i == k + 11 && i_in.stack_insert_enable) begin
				exp.push_back(ETY[15:8]);
				exp.push_back(ETY[7:0]);
				for (int j = 9; j >= 0; j--) exp.push_back(pay[j*8 +: 8]);
			end
		end
		tail = cpu || (len - 1 >= k && len - 1 < k + 12) || len - 1 >= t;
		d = 15 + (i_in.stack_insert_enable ? 12 : 0);
		if (eth && ip && i_in.internal_frame_header.rewrite_diffserv_enable &&
			!i_in.internal_frame_header.keep_diffserv_code)
			exp[d] = {i_in.internal_frame_header.diffserv_code, f[t + 3][1:0]};
		r0 = n_runt;
		for (int i = 0; i < len; i++) put(f[i], i == 0, i == len - 1);
		i_in_valid = 0;
		for (int w = 0; w < 300 && got.size() < exp.size(); w++)
			@(negedge i_clock);
		repeat (4) @(negedge i_clock);
		check(got.size(), exp.size());
		foreach (exp[i])
			if (i < got.size()) check(got[i].data, exp[i]);
		if (got.size() > 0) check(got[got.size() - 1].eof, tail);
		// a dropped eof byte is flagged exactly once
		check(n_runt - r0, !tail);
		if (k == 0 && got.size() > 0) check(got[0].sof, 1);
		check(o_frame_path_action, bad ? 3'h0 : act);
		check(o_frame_path_point, bad ? 5'h0 : pt);
		check(o_to_cpu, cpu);
		check(o_cpu_queue_mask, m);
	endtask
	task give_verdict();
		if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#400000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge i_clock);
		@(negedge i_clock);
		i_rst_n = 1;
		@(negedge i_clock);
		check(o_in_ready, 1);
		send(20, 0);
		i_in.internal_frame_header.vlan_tag_strip_count = 2'h2;
		slow = 1;
		send(24, 0);
		i_in.stack_insert_enable = 1;
		send(24, 1);
		i_in.internal_frame_header.rewrite_diffserv_enable = 1;
		i_in.internal_frame_header.diffserv_code = 6'h2d;
		send(40, 1);
		i_in.internal_frame_header.keep_diffserv_code = 1;
		send(40, 1);
		i_in = '0;
		i_in.encap_halfword_strip_count = 5'h03;
		i_in.internal_frame_header.vlan_tag_strip_count = 2'h1;
		send(30, 0);
		// non-ethernet after the strip: tags stay, nothing inserted
		i_in.header_kind_after_strip = 2'h2;
		i_in.stack_insert_enable = 1;
		send(30, 0);
		// eof byte falls inside the popped tag
		i_in = '0;
		i_in.internal_frame_header.vlan_tag_strip_count = 2'h1;
		send(14, 0);
		i_in = '0;
		i_in.internal_frame_header.cpu_queue_mask = 8'ha5;
		for (int a = 0; a < 9; a++) begin
			i_in.internal_frame_header.frame_path_action = (a == 8) ? 3'h4 : a[2:0];
			i_in.internal_frame_header.frame_path_point = (a == 8) ? 5'h1a : 5'h05 + a[4:0];
			send(16, 0);
		end
		i_in = '0;
		got = {};
		hold = 1;
		n = 0;
		i_in_valid = 1;
		i_in.sof = 1;
		for (int w = 0; w < 40 && o_in_ready === 1'b1; w++) begin
			@(negedge i_clock);
			n++;
			i_in.sof = 0;
			i_in.data = n[7:0];
		end
		check(n >= 16 && n <= 18, 1);
		// the refused word keeps standing and now closes the frame
		i_in.eof = 1;
		hold = 0;
		while (o_in_ready !== 1'b1) @(negedge i_clock);
		@(negedge i_clock);
		i_in_valid = 0;
		repeat (80) @(negedge i_clock);
		check(got.size(), n + 1);
		foreach (got[i]) check(got[i].data, i[7:0]);
		give_verdict();
	end
endmodule // test_frame_header_rewrite_control
